//--- sei_pkg.sv
// Package for the serial error and interrupt logic: constants and carriers.
// Assumes a single 100 MHz clock and plain control ports, no register bus.
package sei_pkg;
    // ************************************************************
    // Timing and reset values
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [3:0] LAST_HALF = 4'hF;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [3:0] FLAGS_RST = 4'h1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic receive_irq_enable;
        logic master_select;
        logic clock_phase;
        logic serial_enable;
        logic transmit_irq_enable;
    } sei_ctrl_t;

    typedef struct packed {
        logic error_irq_enable;
        logic mode_fault_enable;
        logic [1:0] rate_select;
    } sei_cfg_t;

    typedef struct packed {
        logic receive_full_flag;
        logic overflow_flag;
        logic mode_fault_flag;
        logic transmit_empty_flag;
    } sei_flags_t;
endpackage : sei_pkg

//--- sei_spi.sv
// Serial interface core with start latency, error flags and interrupt requests.
// Assumes CPU strobes are one-cycle pulses on clk; link pins are asynchronous.
// Function
// - Master transfers start only from data writes
// - Phase sets first half idle or edge
// - Master divider runs only when enabled master
// - Start delay at most one bit time
// - Unread data at bit one sets overflow
// - One error enable covers overflow and fault
// - All receive and error requests share output
// - Fault flag sets only with fault enable
// - Master fault while select input is low
// - Master fault disables, empties, clears counter, releases
// - Fault leaves master select unchanged
// - Slave fault when select rises mid transfer
// - Slave transfer bounds depend on clock phase
// - Phase zero select-deselect faults; phase one not
// - Slave fault keeps enable; toggle enable aborts
// - Deselected slave floats output, ignores clocks
// - Fault clears by status read, control write
// - Receive request needs enable and serial enable
// - Transmit request follows empty flag and enable
// - Flags set on each byte move
// - Receive flag clears by status, data read
// - Data write while enabled clears empty flag, queues byte
`timescale 1ns/1ps
`default_nettype none
module sei_spi (
    input wire logic clk,
    input wire logic rst,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic data_rd,
    input wire logic status_rd,
    input wire logic control_wr,
    input wire sei_pkg::sei_ctrl_t control_wdata,
    input wire logic config_wr,
    input wire sei_pkg::sei_cfg_t config_wdata,
    output logic [7:0] serial_data_reg,
    output sei_pkg::sei_ctrl_t control_reg,
    output sei_pkg::sei_cfg_t config_reg,
    output sei_pkg::sei_flags_t status_control_reg,
    output logic rx_err_irq,
    output logic tx_irq,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic slave_select_n_i
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [6:0] half_cycles(input logic [1:0] rate);
        case (rate)
            2'h0: half_cycles = sei_pkg::HALF_DIV2;
            2'h1: half_cycles = sei_pkg::HALF_DIV8;
            2'h2: half_cycles = sei_pkg::HALF_DIV32;
            default: half_cycles = sei_pkg::HALF_DIV128;
        endcase
    endfunction : half_cycles

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Second stage only is read; third stage gives the edge reference.
    logic [2:0] sck_s_q, ss_s_q;
    logic [1:0] mosi_s_q, miso_s_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            {sck_s_q, mosi_s_q, miso_s_q} <= 7'h00;
            ss_s_q <= 3'h7;
        end else begin
            sck_s_q <= {sck_s_q[1:0], serial_clock_pin_i};
            ss_s_q <= {ss_s_q[1:0], slave_select_n_i};
            mosi_s_q <= {mosi_s_q[0], mosi_i};
            miso_s_q <= {miso_s_q[0], miso_i};
        end
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {SEI_IDLE, SEI_WAIT, SEI_SHIFT} sei_st_t;
    sei_st_t st_q, st_d;
    sei_pkg::sei_ctrl_t ctrl_q, ctrl_d;
    sei_pkg::sei_cfg_t cfg_q, cfg_d;
    sei_pkg::sei_flags_t fl_q, fl_d;
    logic [7:0] rx_q, rx_d, tx_q, tx_d, sr_q, sr_d;
    logic tx_full_q, tx_full_d, samp_q, samp_d, disc_q, disc_d;
    logic [6:0] div_q, div_d;
    logic [3:0] h_q, h_d, nbit_q, nbit_d;
    logic rx_arm_q, rx_arm_d, ov_arm_q, ov_arm_d, mf_arm_q, mf_arm_d;
    logic irq_re_q, irq_re_d, irq_tx_q, irq_tx_d;
    logic sck_q, sck_d, mosi_q, mosi_d, miso_q, miso_d;
    logic moe_q, moe_d, soe_q, soe_d;

    logic tick, done, first_samp, ss_low, lead, trail, mf_cond, master_on;
    logic [7:0] rx_byte;

    always_comb begin
        st_d = st_q;
        {ctrl_d, cfg_d, fl_d} = {ctrl_q, cfg_q, fl_q};
        {rx_d, tx_d, sr_d} = {rx_q, tx_q, sr_q};
        {tx_full_d, samp_d, disc_d} = {tx_full_q, samp_q, disc_q};
        {div_d, h_d, nbit_d} = {div_q, h_q, nbit_q};
        {rx_arm_d, ov_arm_d, mf_arm_d} = {rx_arm_q, ov_arm_q, mf_arm_q};
        done = 1'b0;
        first_samp = 1'b0;
        rx_byte = {sr_q[6:0], samp_q};
        master_on = ctrl_q.serial_enable & ctrl_q.master_select;
        ss_low = ~ss_s_q[1];
        // Slave edges are dropped entirely while deselected
        lead = ss_low & sck_s_q[1] & ~sck_s_q[2];
        trail = ss_low & ~sck_s_q[1] & sck_s_q[2];
        tick = 1'b0;

        // ********************************************************
        // Software register writes
        // ********************************************************
        if (control_wr) begin
            ctrl_d = control_wdata;
        end
        if (config_wr) begin
            cfg_d = config_wdata;
        end
        if (data_wr) begin
            tx_d = data_wdata;
            tx_full_d = 1'b1;
            fl_d.transmit_empty_flag = 1'b0;
        end

        // ********************************************************
        // Master bit clock
        // ********************************************************
        // Free running so the start is only aligned to the next half bit
        if (master_on) begin
            if (div_q >= half_cycles(cfg_q.rate_select) - 7'h01) begin
                div_d = 7'h00;
                tick = 1'b1;
            end else begin
                div_d = div_q + 7'h01;
            end
        end else begin
            div_d = 7'h00;
        end

        // ********************************************************
        // Shifter
        // ********************************************************
        case (st_q)
            SEI_IDLE: begin
                if (tx_full_q && !data_wr) begin
                    sr_d = tx_q;
                    tx_full_d = 1'b0;
                    fl_d.transmit_empty_flag = 1'b1;
                end
                if (tx_full_q && master_on && !data_wr) begin
                    st_d = SEI_WAIT;
                end else if (!ctrl_q.master_select && ctrl_q.serial_enable) begin
                    if (!ctrl_q.clock_phase && ss_low && ss_s_q[2]) begin
                        st_d = SEI_SHIFT;
                        nbit_d = 4'h0;
                    end else if (ctrl_q.clock_phase && lead) begin
                        st_d = SEI_SHIFT;
                        nbit_d = 4'h0;
                    end
                end
            end
            SEI_WAIT: begin
                if (tick) begin
                    st_d = SEI_SHIFT;
                    h_d = 4'h0;
                    nbit_d = 4'h0;
                end
            end
            SEI_SHIFT: begin
                if (ctrl_q.master_select) begin
                    if (tick) begin
                        if (h_q == sei_pkg::LAST_HALF) begin
                            done = 1'b1;
                        end else begin
                            h_d = h_q + 4'h1;
                            if (!h_q[0]) begin
                                samp_d = miso_s_q[1];
                                first_samp = (h_q == 4'h0);
                            end else begin
                                sr_d = {sr_q[6:0], samp_q};
                            end
                        end
                    end
                end else begin
                    // CLOCK_PHASE 1 samples on the trailing edge, CLOCK_PHASE 0 on the leading
                    if (ctrl_q.clock_phase ? trail : lead) begin
                        if (ctrl_q.clock_phase && nbit_q == sei_pkg::BITS_PER_BYTE - 4'h1) begin
                            done = 1'b1;
                            rx_byte = {sr_q[6:0], mosi_s_q[1]};
                        end else begin
                            samp_d = mosi_s_q[1];
                        end
                        first_samp = (nbit_q == 4'h0);
                        nbit_d = nbit_q + 4'h1;
                    end else if (ctrl_q.clock_phase ? lead : trail) begin
                        if (!ctrl_q.clock_phase && nbit_q == sei_pkg::BITS_PER_BYTE) begin
                            done = 1'b1;
                        end else if (nbit_q != 4'h0) begin
                            sr_d = {sr_q[6:0], samp_q};
                        end
                    end
                end
                if (done) begin
                    st_d = SEI_IDLE;
                    disc_d = 1'b0;
                    if (!disc_q) begin
                        rx_d = rx_byte;
                        fl_d.receive_full_flag = 1'b1;
                    end
                end
            end
            default: st_d = SEI_IDLE;
        endcase

        // ********************************************************
        // Status flags
        // ********************************************************
        if (first_samp && fl_q.receive_full_flag) begin
            disc_d = 1'b1;
            fl_d.overflow_flag = 1'b1;
        end
        // Flag clears: arm on status read, finish on the second access
        if (status_rd) begin
            rx_arm_d = fl_q.receive_full_flag;
            ov_arm_d = fl_q.overflow_flag;
            mf_arm_d = fl_q.mode_fault_flag;
        end
        if (data_rd && rx_arm_q && !(done && !disc_q)) begin
            fl_d.receive_full_flag = 1'b0;
            rx_arm_d = 1'b0;
        end
        if (data_rd && ov_arm_q && !(first_samp && fl_q.receive_full_flag)) begin
            fl_d.overflow_flag = 1'b0;
            ov_arm_d = 1'b0;
        end

        mf_cond = 1'b0;
        if (cfg_q.mode_fault_enable && ctrl_q.serial_enable) begin
            if (ctrl_q.master_select) begin
                mf_cond = ss_low;
            end else begin
                // CLOCK_PHASE 0 is in transfer from select low, so deselect faults
                mf_cond = (st_q == SEI_SHIFT) && !ss_low;
            end
        end
        if (mf_cond) begin
            mf_arm_d = 1'b0;
        end
        if (control_wr && mf_arm_q && !mf_cond) begin
            fl_d.mode_fault_flag = 1'b0;
            mf_arm_d = 1'b0;
        end
        if (mf_cond) begin
            fl_d.mode_fault_flag = 1'b1;
            if (ctrl_q.master_select) begin
                ctrl_d.serial_enable = 1'b0;
                fl_d.transmit_empty_flag = 1'b1;
                st_d = SEI_IDLE;
            end
        end
        // Slave fault leaves the transfer running until software toggles enable
        if (!ctrl_q.serial_enable || (!ctrl_q.master_select && !ss_low && st_q == SEI_SHIFT
            && !cfg_q.mode_fault_enable)) begin
            st_d = SEI_IDLE;
            h_d = 4'h0;
            nbit_d = 4'h0;
            disc_d = 1'b0;
        end
        if (!ctrl_q.serial_enable) begin
            sr_d = sei_pkg::DATA_RST;
            fl_d.transmit_empty_flag = 1'b1;
            tx_full_d = 1'b0;
        end

        // ********************************************************
        // Registered outputs
        // ********************************************************
        irq_re_d = (fl_q.receive_full_flag & ctrl_q.receive_irq_enable
                   & ctrl_q.serial_enable)
                   | (cfg_q.error_irq_enable
                   & (fl_q.overflow_flag | fl_q.mode_fault_flag));
        irq_tx_d = fl_q.transmit_empty_flag & ctrl_q.transmit_irq_enable;
        sck_d = master_on && st_q == SEI_SHIFT && (h_q[0] ^ ctrl_q.clock_phase);
        mosi_d = sr_q[7];
        miso_d = sr_q[7];
        moe_d = master_on;
        soe_d = ctrl_q.serial_enable && !ctrl_q.master_select && ss_low;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= SEI_IDLE;
            ctrl_q <= '0;
            cfg_q <= {1'b0, 1'b0, sei_pkg::RATE_RST};
            fl_q <= sei_pkg::FLAGS_RST;
            {rx_q, tx_q, sr_q} <= {3{sei_pkg::DATA_RST}};
            {tx_full_q, samp_q, disc_q, div_q, h_q, nbit_q} <= 18'h0_0000;
            {rx_arm_q, ov_arm_q, mf_arm_q, irq_re_q, irq_tx_q} <= 5'h00;
            {sck_q, mosi_q, miso_q, moe_q, soe_q} <= 5'h00;
        end else begin
            st_q <= st_d;
            {ctrl_q, cfg_q, fl_q} <= {ctrl_d, cfg_d, fl_d};
            {rx_q, tx_q, sr_q} <= {rx_d, tx_d, sr_d};
            {tx_full_q, samp_q, disc_q} <= {tx_full_d, samp_d, disc_d};
            {div_q, h_q, nbit_q} <= {div_d, h_d, nbit_d};
            {rx_arm_q, ov_arm_q, mf_arm_q} <= {rx_arm_d, ov_arm_d, mf_arm_d};
            {irq_re_q, irq_tx_q, moe_q, soe_q} <= {irq_re_d, irq_tx_d, moe_d, soe_d};
            {sck_q, mosi_q, miso_q} <= {sck_d, mosi_d, miso_d};
        end
    end

    assign serial_data_reg = rx_q;
    assign control_reg = ctrl_q;
    assign config_reg = cfg_q;
    assign status_control_reg = fl_q;
    assign {rx_err_irq, tx_irq} = {irq_re_q, irq_tx_q};
    assign {serial_clock_pin_o, mosi_o, miso_o} = {sck_q, mosi_q, miso_q};
    assign {serial_clock_pin_oe, mosi_oe} = {moe_q, moe_q};
    assign miso_oe = soe_q;
endmodule : sei_spi
`default_nettype wire

//--- sei_spi_checker.sv
// Port-level assertions for the serial error and interrupt block.
// Assumes it is bound to sei_spi and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sei_spi_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic data_wr,
    input wire logic control_wr,
    input wire sei_pkg::sei_ctrl_t control_reg,
    input wire sei_pkg::sei_cfg_t config_reg,
    input wire sei_pkg::sei_flags_t status_control_reg,
    input wire logic [7:0] serial_data_reg,
    input wire logic rx_err_irq,
    input wire logic tx_irq,
    input wire logic serial_clock_pin_oe,
    input wire logic miso_oe,
    input wire logic slave_select_n_i
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic tx_src;
    logic rx_src;
    assign tx_src = status_control_reg.transmit_empty_flag & control_reg.transmit_irq_enable;
    // Receive needs serial enable; error sources share one enable
    assign rx_src = (status_control_reg.receive_full_flag & control_reg.receive_irq_enable
        & control_reg.serial_enable) | (config_reg.error_irq_enable
        & (status_control_reg.overflow_flag | status_control_reg.mode_fault_flag));
    sequence s_fault_set;
        $rose(status_control_reg.mode_fault_flag) && !$past(control_wr);
    endsequence
    // ************************************************************
    // Assertions
    // ************************************************************
    a_tx_irq_on: assert property (tx_src ##1 tx_src |-> tx_irq)
        else $error("transmit request missing");
    a_tx_irq_off: assert property (!tx_src ##1 !tx_src |-> !tx_irq)
        else $error("transmit request without source");
    a_rx_irq_on: assert property (rx_src ##1 rx_src |-> rx_err_irq)
        else $error("receive or error request missing");
    a_rx_irq_off: assert property (!rx_src ##1 !rx_src |-> !rx_err_irq)
        else $error("receive or error request without source");
    a_fault_needs_enable: assert property (s_fault_set |-> config_reg.mode_fault_enable
        || $past(config_reg.mode_fault_enable) || $past(config_reg.mode_fault_enable, 2))
        else $error("mode fault set while detection disabled");
    a_master_fault_stops: assert property (s_fault_set and $past(control_reg.master_select)
        |-> ##[0:2] (!control_reg.serial_enable && status_control_reg.transmit_empty_flag))
        else $error("master fault left interface enabled");
    a_fault_keeps_mode: assert property (s_fault_set
        |-> control_reg.master_select == $past(control_reg.master_select))
        else $error("mode fault changed master select");
    a_slave_keeps_enable: assert property (s_fault_set and !$past(control_reg.master_select)
        |-> control_reg.serial_enable == $past(control_reg.serial_enable))
        else $error("slave fault changed serial enable");
    a_ovf_needs_full: assert property ($rose(status_control_reg.overflow_flag)
        |-> status_control_reg.receive_full_flag)
        else $error("overflow without unread data");
    a_full_keeps_data: assert property (status_control_reg.receive_full_flag
        && $past(status_control_reg.receive_full_flag) |-> $stable(serial_data_reg))
        else $error("unread byte overwritten");
    a_deselect_floats: assert property (slave_select_n_i [*5] |-> !miso_oe)
        else $error("output driven while deselected");
    a_write_empties: assert property (data_wr && control_reg.serial_enable
        |=> !status_control_reg.transmit_empty_flag)
        else $error("data write left empty flag set");
    a_idle_no_clock: assert property (!control_reg.serial_enable [*3]
        |-> !serial_clock_pin_oe)
        else $error("clock driven while disabled");
endmodule : sei_spi_checker
bind sei_spi sei_spi_checker u_chk (.clk(clk), .rst(rst), .data_wr(data_wr),
    .control_wr(control_wr), .control_reg(control_reg), .config_reg(config_reg),
    .status_control_reg(status_control_reg), .serial_data_reg(serial_data_reg),
    .rx_err_irq(rx_err_irq), .tx_irq(tx_irq), .serial_clock_pin_oe(serial_clock_pin_oe),
    .miso_oe(miso_oe), .slave_select_n_i(slave_select_n_i));
`default_nettype wire

//--- sei_far_slave.sv
// Behavioural remote slave on the link, phase 0, clock idle low.
// Assumes the bench selects it only while the block is master.
`timescale 1ns/1ps
`default_nettype none
module sei_far_slave (
    input wire logic clk,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic junk;
    initial begin
        sh = 8'h00;
        rx_byte = 8'h00;
        junk = 1'b0;
    end
    // Released line toggles so a stale value is never mistaken for data
    always @(posedge clk) junk <= ~junk;
    always @(negedge sel_n) sh = tx_byte;
    assign miso = sel_n ? junk : sh[7];
    always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
    always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
endmodule : sei_far_slave
`default_nettype wire

//--- tb_sei_spi.sv
// Self-checking bench for sei_spi: master, overflow, fault and slave cases.
// Assumes the remote slave model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb_sei_spi;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0, control_wr = 1'b0, config_wr = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    sei_pkg::sei_ctrl_t control_wdata = '0;
    sei_pkg::sei_cfg_t config_wdata = '0;
    logic [7:0] serial_data_reg, far_tx = 8'h00, far_rx, b0, b1;
    sei_pkg::sei_ctrl_t control_reg;
    sei_pkg::sei_cfg_t config_reg;
    sei_pkg::sei_flags_t flags;
    logic rx_err_irq, tx_irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, far_miso;
    logic tb_sck = 1'b0, tb_mosi = 1'b0, ss_n = 1'b1, far_sel_n = 1'b1, prev_rf = 1'b0;
    wire logic sck_w = sck_oe ? sck_o : tb_sck;
    wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic miso_w = miso_oe ? miso_o : far_miso;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] exp_q[$];
    always #5 clk = ~clk;
    sei_spi u_dut (.clk(clk), .rst(rst), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rd(data_rd), .status_rd(status_rd), .control_wr(control_wr),
        .control_wdata(control_wdata), .config_wr(config_wr), .config_wdata(config_wdata),
        .serial_data_reg(serial_data_reg), .control_reg(control_reg), .config_reg(config_reg),
        .status_control_reg(flags), .rx_err_irq(rx_err_irq), .tx_irq(tx_irq),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_n_i(ss_n));
    sei_far_slave u_far (.clk(clk), .sel_n(far_sel_n), .sck(sck_w), .mosi(mosi_w),
        .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));
    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // Each received byte is compared with the oldest noted expectation
    always @(negedge clk) begin
        prev_rf <= flags.receive_full_flag;
        if (!rst && flags.receive_full_flag === 1'b1 && prev_rf === 1'b0) begin
            if (exp_q.size() == 0) check("unexpected byte", serial_data_reg, 8'h00);
            else check("received byte", serial_data_reg, exp_q.pop_front());
        end
    end
    // ************************************************************
    // Stimulus
    // ************************************************************
    // Ops: 0 data write, 1 data read, 2 status read, 3 control write, 4 config write
    task automatic cpu(input int op, input logic [7:0] v);
        @(negedge clk);
        case (op)
            0: begin
                data_wr = 1'b1;
                data_wdata = v;
            end
            1: data_rd = 1'b1;
            2: status_rd = 1'b1;
            3: begin
                control_wr = 1'b1;
                control_wdata = sei_pkg::sei_ctrl_t'(v[4:0]);
            end
            default: begin
                config_wr = 1'b1;
                config_wdata = sei_pkg::sei_cfg_t'(v[3:0]);
            end
        endcase
        @(negedge clk);
        {data_wr, data_rd, status_rd, control_wr, config_wr} = 5'h00;
    endtask : cpu
    task automatic wait_flag(input int idx);
        int n;
        for (n = 0; n < 4000 && flags[idx] !== 1'b1; n++) @(negedge clk);
        if (n == 4000) begin
            fail_count++;
            $display("[FAIL] flag %0d never set", idx);
            summarize();
        end
    endtask : wait_flag
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Master byte exchange with the remote slave; waits on the given flag
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input int idx);
        far_tx = rx;
        far_sel_n = 1'b0;
        cpu(0, tx);
        wait_flag(idx);
        // Overflow rises at the first bit, so always wait out the whole byte
        idle(1100);
        far_sel_n = 1'b1;
        check("remote got", far_rx, tx);
    endtask : xfer
    initial begin
        void'($urandom(32'hda90));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        idle(2);
        rst = 1'b0;
        check("reset flags", {4'h0, flags}, 8'h01);
        check("reset irqs", {6'h00, rx_err_irq, tx_irq}, 8'h00);
        cpu(4, 8'h0B);
        cpu(3, 8'h1B);
        idle(3);
        check("tx request", {7'h00, tx_irq}, 8'h01);
        exp_q.push_back(b0);
        xfer(8'h3C, b0, 3);
        idle(3);
        check("rx request", {7'h00, rx_err_irq}, 8'h01);
        xfer(8'hC3, b1, 2);
        check("kept byte", serial_data_reg, b0);
        cpu(2, 8'h00);
        cpu(1, 8'h00);
        cpu(2, 8'h00);
        idle(3);
        check("flags cleared", {4'h0, flags}, 8'h01);
        ss_n = 1'b0;
        idle(20);
        check("fault disabled", {7'h00, flags.mode_fault_flag}, 8'h00);
        cpu(4, 8'h0F);
        wait_flag(1);
        idle(3);
        check("master fault", {5'h00, control_reg.serial_enable, control_reg.master_select,
            flags.transmit_empty_flag}, 8'h03);
        check("error request", {7'h00, rx_err_irq}, 8'h01);
        cpu(2, 8'h00);
        cpu(3, 8'h1B);
        idle(3);
        check("fault held", {7'h00, flags.mode_fault_flag}, 8'h01);
        ss_n = 1'b1;
        idle(6);
        cpu(2, 8'h00);
        cpu(3, 8'h02);
        idle(3);
        check("fault cleared", {7'h00, flags.mode_fault_flag}, 8'h00);
        ss_n = 1'b0;
        idle(10);
        ss_n = 1'b1;
        idle(10);
        check("phase0 fault", {6'h00, flags.mode_fault_flag, control_reg.serial_enable},
            8'h03);
        cpu(3, 8'h04);
        cpu(2, 8'h00);
        cpu(3, 8'h06);
        ss_n = 1'b0;
        idle(10);
        ss_n = 1'b1;
        idle(10);
        check("phase1 no fault", {7'h00, flags.mode_fault_flag}, 8'h00);
        ss_n = 1'b0;
        idle(6);
        exp_q.push_back(b1);
        for (int i = 7; i >= 0; i--) begin
            tb_sck = 1'b1;
            tb_mosi = b1[i];
            idle(8);
            tb_sck = 1'b0;
            idle(8);
        end
        wait_flag(3);
        ss_n = 1'b1;
        idle(10);
        check("slave clean end", {7'h00, flags.mode_fault_flag}, 8'h00);
        check("all bytes seen", 8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule : tb_sei_spi
`default_nettype wire
